// file: hw/pcg_pkg.sv
// Purpose: constants and types for the peripheral clock gating block
// Assumes: 32-bit register port, one 10 MHz clock
// Notes: offsets are byte addresses in the system control space
package pcg_pkg;
    // ==================================================
    // register map
    localparam logic [11:0] RUN_ONE_OFS = 12'h104;
    localparam logic [11:0] SLEEP_ONE_OFS = 12'h114;
    localparam logic [11:0] DEEP_ONE_OFS = 12'h124;
    localparam logic [11:0] RUN_ZERO_OFS = 12'h100;
    localparam logic [11:0] SLEEP_ZERO_OFS = 12'h110;
    localparam logic [11:0] DEEP_ZERO_OFS = 12'h120;
    localparam logic [11:0] CFG_OFS = 12'h060;
    localparam logic [11:0] INT_STAT_OFS = 12'h200;
    localparam logic [11:0] INT_MASK_OFS = 12'h204;
    localparam logic [11:0] STATE_OFS = 12'h208;
    // ==================================================
    // fields
    localparam logic [31:0] ONE_WMASK = 32'h070F_5037;
    localparam logic [31:0] ZERO_WMASK = 32'h0000_0048;
    localparam int HIBERNATE_BIT = 6;
    localparam int WDOG_BIT = 3;
    localparam int AUTO_GATE_BIT = 27;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam int N_UNITS = 16;
    // unit index -> bit position in gate set one
    localparam logic [4:0] UNIT_POS [0:14] = '{
        5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h0C, 5'h0E,
        5'h10, 5'h11, 5'h12, 5'h13, 5'h18, 5'h19, 5'h1A, 5'h00};
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_MODE = 1;

    typedef enum logic [1:0] {
        PCG_RUN = 2'b00,
        PCG_SLEEP = 2'b01,
        PCG_DEEP = 2'b10
    } pcg_mode_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pcg_req_t;
endpackage

// file: hw/pcg_top.sv
// Purpose: peripheral clock gating registers and enables
// Assumes: unit accesses arrive as a select of one or more units with a strobe
// Notes: unit index 0..15: async 0-2, sync 3-4, two-wire 5-6,
//        counters 7-10, comparators 11-13, watchdog 14, hibernation 15
`timescale 1ns/1ps
module pcg_top
    import pcg_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [1:0] i_mode,
    input wire logic [N_UNITS-1:0] i_unit_sel,
    input wire logic i_unit_strobe,
    output logic [N_UNITS-1:0] o_unit_clk_en,
    output logic o_bus_fault,
    output logic o_irq
);
    // ==================================================
    // registers
    pcg_req_t req;
    logic [31:0] run_gate_set_one;
    logic [31:0] sleep_gate_set_one;
    logic [31:0] deep_sleep_gate_set_one;
    logic [31:0] run_gate_set_zero;
    logic [31:0] sleep_gate_set_zero;
    logic [31:0] deep_sleep_gate_set_zero;
    logic auto_clock_gating_bit;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    pcg_mode_t mode_q;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // ==================================================
    // decode
    wire wr_run1 = req.wr && (req.addr == RUN_ONE_OFS);
    wire wr_slp1 = req.wr && (req.addr == SLEEP_ONE_OFS);
    wire wr_dep1 = req.wr && (req.addr == DEEP_ONE_OFS);
    wire wr_run0 = req.wr && (req.addr == RUN_ZERO_OFS);
    wire wr_slp0 = req.wr && (req.addr == SLEEP_ZERO_OFS);
    wire wr_dep0 = req.wr && (req.addr == DEEP_ZERO_OFS);
    wire wr_cfg = req.wr && (req.addr == CFG_OFS);
    wire wr_stat = req.wr && (req.addr == INT_STAT_OFS);
    wire wr_mask = req.wr && (req.addr == INT_MASK_OFS);

    logic [31:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            RUN_ONE_OFS: rd_mux = run_gate_set_one;
            SLEEP_ONE_OFS: rd_mux = sleep_gate_set_one;
            DEEP_ONE_OFS: rd_mux = deep_sleep_gate_set_one;
            RUN_ZERO_OFS: rd_mux = run_gate_set_zero;
            SLEEP_ZERO_OFS: rd_mux = sleep_gate_set_zero;
            DEEP_ZERO_OFS: rd_mux = deep_sleep_gate_set_zero;
            CFG_OFS: rd_mux = 32'(auto_clock_gating_bit) << AUTO_GATE_BIT;
            INT_STAT_OFS: rd_mux = {30'h0, int_stat};
            INT_MASK_OFS: rd_mux = {30'h0, int_mask};
            STATE_OFS: rd_mux = {30'h0, mode_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ==================================================
    // gate registers; reserved bits never stored so they read zero
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_gate_set_one <= GATE_RESET;
            sleep_gate_set_one <= GATE_RESET;
            deep_sleep_gate_set_one <= GATE_RESET;
            run_gate_set_zero <= GATE_RESET;
            sleep_gate_set_zero <= GATE_RESET;
            deep_sleep_gate_set_zero <= GATE_RESET;
            auto_clock_gating_bit <= 1'b0;
            int_mask <= 2'h0;
        end else begin
            if (wr_run1) run_gate_set_one <= req.wdata & ONE_WMASK;
            if (wr_slp1) sleep_gate_set_one <= req.wdata & ONE_WMASK;
            if (wr_dep1) deep_sleep_gate_set_one <= req.wdata & ONE_WMASK;
            if (wr_run0) run_gate_set_zero <= req.wdata & ZERO_WMASK;
            if (wr_slp0) sleep_gate_set_zero <= req.wdata & ZERO_WMASK;
            if (wr_dep0) deep_sleep_gate_set_zero <= req.wdata & ZERO_WMASK;
            if (wr_cfg) auto_clock_gating_bit <= req.wdata[AUTO_GATE_BIT];
            if (wr_mask) int_mask <= req.wdata[1:0];
        end
    end

    // ==================================================
    // active set selection
    wire use_sleep = auto_clock_gating_bit && (mode_q == PCG_SLEEP);
    wire use_deep = auto_clock_gating_bit && (mode_q == PCG_DEEP);
    wire [31:0] act_one = use_deep ? deep_sleep_gate_set_one :
        use_sleep ? sleep_gate_set_one : run_gate_set_one;
    wire [31:0] act_zero = use_deep ? deep_sleep_gate_set_zero :
        use_sleep ? sleep_gate_set_zero : run_gate_set_zero;

    logic [N_UNITS-1:0] next_clk_en;
    genvar g;
    generate
        for (g = 0; g < 14; g++) begin : g_one
            assign next_clk_en[g] = act_one[UNIT_POS[g]];

            // each enable follows the set picked by mode and auto gating
            chk_unit_run: assert property (
                @(posedge i_ref_clk) disable iff (!i_arst_n)
                !auto_clock_gating_bit
                |=> o_unit_clk_en[g] == $past(run_gate_set_one[UNIT_POS[g]])
            ) else begin
                $error("unit enable not taken from run set");
            end

            chk_unit_sleep: assert property (
                @(posedge i_ref_clk) disable iff (!i_arst_n)
                (auto_clock_gating_bit && mode_q == PCG_SLEEP)
                |=> o_unit_clk_en[g] == $past(sleep_gate_set_one[UNIT_POS[g]])
            ) else begin
                $error("unit enable not taken from sleep set");
            end

            chk_unit_deep: assert property (
                @(posedge i_ref_clk) disable iff (!i_arst_n)
                (auto_clock_gating_bit && mode_q == PCG_DEEP)
                |=> o_unit_clk_en[g] == $past(deep_sleep_gate_set_one[UNIT_POS[g]])
            ) else begin
                $error("unit enable not taken from deep sleep set");
            end
        end
    endgenerate
    assign next_clk_en[14] = act_zero[WDOG_BIT];
    assign next_clk_en[15] = act_zero[HIBERNATE_BIT];

    // illegal mode code 2'b11 is held off as run
    pcg_mode_t next_mode;
    assign next_mode = (i_mode == 2'b11) ? PCG_RUN : pcg_mode_t'(i_mode);
    wire fault_now = i_unit_strobe && |(i_unit_sel & ~o_unit_clk_en);
    wire mode_change = next_mode != mode_q;

    // ==================================================
    // outputs and interrupt status
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_unit_clk_en <= '0;
            o_bus_fault <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_irq <= 1'b0;
            int_stat <= 2'h0;
            mode_q <= PCG_RUN;
        end else begin
            o_unit_clk_en <= next_clk_en;
            o_bus_fault <= fault_now;
            o_rdata <= req.rd ? rd_mux : 32'h0000_0000;
            mode_q <= next_mode;
            // set wins over a same-cycle clear
            int_stat[IRQ_FAULT] <= fault_now ||
                (int_stat[IRQ_FAULT] && !(wr_stat && req.wdata[IRQ_FAULT]));
            int_stat[IRQ_MODE] <= mode_change ||
                (int_stat[IRQ_MODE] && !(wr_stat && req.wdata[IRQ_MODE]));
            o_irq <= |(int_stat & int_mask);
        end
    end

    // ==================================================
    // checks
    chk_fault_when_gated: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        fault_now
        |=> o_bus_fault
    ) else begin
        $error("gated access gave no fault");
    end

    chk_no_fault_enabled: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_unit_strobe && (i_unit_sel & ~o_unit_clk_en) == '0)
        |=> !o_bus_fault
    ) else begin
        $error("fault on clocked unit");
    end

    chk_run_set_applies: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (!auto_clock_gating_bit)
        |=> (o_unit_clk_en[0] == $past(run_gate_set_one[0]))
    ) else begin
        $error("run set not applied");
    end

    chk_sleep_set_applies: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (auto_clock_gating_bit && mode_q == PCG_SLEEP)
        |=> (o_unit_clk_en[13] == $past(sleep_gate_set_one[26]))
    ) else begin
        $error("sleep set not applied");
    end

    chk_deep_wdog: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (auto_clock_gating_bit && mode_q == PCG_DEEP)
        |=> (o_unit_clk_en[14] == $past(deep_sleep_gate_set_zero[WDOG_BIT]))
    ) else begin
        $error("watchdog gate wrong in deep sleep");
    end

    chk_reserved_zero: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (run_gate_set_one & ~ONE_WMASK) == '0
        && (sleep_gate_set_one & ~ONE_WMASK) == '0
    ) else begin
        $error("reserved bit stored");
    end

    chk_run_write_lands: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        wr_run1
        |=> run_gate_set_one == ($past(i_wdata) & ONE_WMASK)
    ) else begin
        $error("run set write lost");
    end

    chk_timer_bit: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (!auto_clock_gating_bit)
        |=> (o_unit_clk_en[10] == $past(run_gate_set_one[19]))
    ) else begin
        $error("counter three gate wrong");
    end

    chk_irq_level: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        |(int_stat & int_mask)
        |=> o_irq
    ) else begin
        $error("irq missing");
    end

    // first edge out of reset must still see every unit unclocked
    chk_reset_all_clear: assert property (
        @(posedge i_ref_clk)
        $rose(i_arst_n)
        |-> (o_unit_clk_en == '0 && {run_gate_set_one, sleep_gate_set_one} == '0)
    ) else begin
        $error("gate state not clear after reset");
    end

    chk_fault_sticky: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        fault_now
        |=> int_stat[IRQ_FAULT]
    ) else begin
        $error("fault status not set");
    end

    chk_fault_needs_strobe: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !i_unit_strobe
        |=> !o_bus_fault
    ) else begin
        $error("fault without unit access");
    end

    chk_sleep_write_lands: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        wr_slp1
        |=> sleep_gate_set_one == ($past(i_wdata) & ONE_WMASK)
    ) else begin
        $error("sleep set write lost");
    end

    chk_deep_write_lands: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        wr_dep1
        |=> deep_sleep_gate_set_one == ($past(i_wdata) & ONE_WMASK)
    ) else begin
        $error("deep sleep set write lost");
    end

    chk_zero_reserved: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        ((run_gate_set_zero | sleep_gate_set_zero | deep_sleep_gate_set_zero) & ~ZERO_WMASK) == '0
        && (deep_sleep_gate_set_one & ~ONE_WMASK) == '0
    ) else begin
        $error("reserved bit stored in gate set");
    end

    chk_deep_zero_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        wr_dep0
        |=> deep_sleep_gate_set_zero == ($past(i_wdata) & ZERO_WMASK)
    ) else begin
        $error("deep sleep set zero write lost");
    end

    chk_deep_hibernate: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (auto_clock_gating_bit && mode_q == PCG_DEEP)
        |=> (o_unit_clk_en[15] == $past(deep_sleep_gate_set_zero[HIBERNATE_BIT]))
    ) else begin
        $error("hibernation gate wrong in deep sleep");
    end

    chk_mode_illegal_run: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_mode == 2'b11)
        |=> mode_q == PCG_RUN
    ) else begin
        $error("illegal mode not held as run");
    end

    chk_irq_clear_level: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !(|(int_stat & int_mask))
        |=> !o_irq
    ) else begin
        $error("irq high with nothing pending");
    end

    chk_rdata_idle: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !req.rd
        |=> o_rdata == '0
    ) else begin
        $error("read data without read strobe");
    end

    chk_run_wdog: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (!auto_clock_gating_bit)
        |=> (o_unit_clk_en[14] == $past(run_gate_set_zero[WDOG_BIT]))
    ) else begin
        $error("watchdog gate not from run set");
    end

    cov_fault: cover property (
        @(posedge i_ref_clk) disable iff (!i_arst_n) o_bus_fault
    );

    cov_sleep: cover property (
        @(posedge i_ref_clk) disable iff (!i_arst_n) use_sleep
    );

    cov_deep: cover property (
        @(posedge i_ref_clk) disable iff (!i_arst_n) use_deep
    );

    cov_irq: cover property (
        @(posedge i_ref_clk) disable iff (!i_arst_n) o_irq
    );

    cov_illegal_mode: cover property (
        @(posedge i_ref_clk) disable iff (!i_arst_n) i_mode == 2'b11
    );
endmodule

// file: sim/pcg_top_tb_top.sv
// Purpose: self-checking bench for the peripheral clock gating block
// Assumes: after time 0, bench drives inputs by non-blocking assignment, at a rising edge or 1ns after it
// Notes: enables and irq lag their cause, so checks wait a few cycles first
`timescale 1ns/1ps
module pcg_top_tb_top;
    import pcg_pkg::*;
    `define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
        $display("Error t=%0t got %0h exp %0h", $time, a, e); end end

    logic i_ref_clk, i_arst_n, i_wr, i_rd, i_unit_strobe;
    logic [11:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rv;
    logic [1:0] i_mode;
    logic [N_UNITS-1:0] i_unit_sel, o_unit_clk_en;
    logic o_bus_fault, o_irq;
    int err_count = 0;
    int checks = 0;

    pcg_top DUT (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_mode(i_mode), .i_unit_sel(i_unit_sel), .i_unit_strobe(i_unit_strobe),
        .o_unit_clk_en(o_unit_clk_en), .o_bus_fault(o_bus_fault), .o_irq(o_irq));

    // ==================================================
    // clock and bus tasks
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic hit(input logic [15:0] sel, input logic exp_fault);
        @(posedge i_ref_clk);
        i_unit_strobe <= 1'b1; i_unit_sel <= sel;
        @(posedge i_ref_clk);
        i_unit_strobe <= 1'b0;
        #1 `CHK(o_bus_fault, exp_fault)
    endtask

    // mode and enable registers add lag, so settle before comparing
    task automatic en_is(input logic [15:0] e);
        repeat (4) @(posedge i_ref_clk);
        #1 `CHK(o_unit_clk_en, e)
    endtask

    task automatic complete_run;
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==================================================
    // tests
    initial begin
        i_arst_n = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 12'h000;
        i_wdata = 32'h0000_0000; i_mode = 2'h0; i_unit_sel = 16'h0000;
        i_unit_strobe = 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        rd(RUN_ONE_OFS, rv); `CHK(rv, 32'h0000_0000)
        rd(DEEP_ZERO_OFS, rv); `CHK(rv, 32'h0000_0000)
        en_is(16'h0000);
        hit(16'h0001, 1'b1);
        wr(RUN_ONE_OFS, 32'hFFFF_FFFF);
        rd(RUN_ONE_OFS, rv); `CHK(rv, 32'h070F_5037)
        en_is(16'h3FFF);
        hit(16'h4000, 1'b1);
        hit(16'h2081, 1'b0);
        wr(RUN_ZERO_OFS, 32'hFFFF_FFFF);
        rd(RUN_ZERO_OFS, rv); `CHK(rv, 32'h0000_0048)
        en_is(16'hFFFF);
        wr(SLEEP_ONE_OFS, 32'hFFFF_FFFE);
        wr(SLEEP_ONE_OFS, 32'h0000_1001);
        rd(SLEEP_ONE_OFS, rv); `CHK(rv, 32'h0000_1001)
        i_mode <= 2'h1;
        en_is(16'hFFFF);
        wr(CFG_OFS, 32'h0800_0000);
        en_is(16'h0021);
        hit(16'h0002, 1'b1);
        wr(DEEP_ONE_OFS, 32'h0402_0030);
        rd(DEEP_ONE_OFS, rv); `CHK(rv, 32'h0402_0030)
        wr(DEEP_ZERO_OFS, 32'h0000_0040);
        i_mode <= 2'h2;
        en_is(16'hA118);
        rd(STATE_OFS, rv); `CHK(rv, 32'h0000_0002)
        hit(16'h4000, 1'b1);
        i_mode <= 2'h3;
        en_is(16'hFFFF);
        #1 `CHK(o_irq, 1'b0)
        rd(INT_STAT_OFS, rv); `CHK(rv[IRQ_FAULT], 1'b1)
        `CHK(rv[IRQ_MODE], 1'b1)
        wr(INT_MASK_OFS, 32'h0000_0001);
        repeat (2) @(posedge i_ref_clk);
        #1 `CHK(o_irq, 1'b1)
        wr(INT_STAT_OFS, 32'h0000_0001);
        repeat (2) @(posedge i_ref_clk);
        #1 `CHK(o_irq, 1'b0)
        rd(12'h3FC, rv); `CHK(rv, 32'h0000_0000)
        complete_run();
    end

    // ==================================================
    // watchdog: the sequence needs well under 400 cycles
    initial begin
        #(2000 * 100);
        err_count++;
        complete_run();
    end
endmodule
